// ---- inc/cam_front_consts.svh ----
// Register offsets, field positions, reset values and timing figures of the front end.
`ifndef CAM_FRONT_CONSTS_SVH
`define CAM_FRONT_CONSTS_SVH
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_FRAMES    8'h08
`define OFF_SKIP      8'h0C
`define OFF_WIN_PIX   8'h10
`define OFF_WIN_LINE  8'h14
`define OFF_ROI_PIX   8'h18
`define OFF_ROI_LINE  8'h1C
`define OFF_DECIM     8'h20
`define OFF_TRIG_CFG  8'h24
`define OFF_TRIG_OUT  8'h28
`define OFF_TIMER     8'h2C
`define OFF_CAMCLK    8'h30
`define OFF_LUT_ADDR  8'h34
`define OFF_LUT_DATA  8'h38
`define CTRL_START    0
`define CTRL_LUT16    1
`define CTRL_INTERL   2
`define CTRL_EVEN     3
`define CTRL_LUT_EN   4
`define DEC_TAP0_H    4
`define DEC_TAP0_V    5
`define DEC_TAP1_H    6
`define DEC_TAP1_V    7
`define RST_CTRL      32'h0000_0000
`define RST_WIN       32'h0000_0000
`define RST_CAMCLK    16'h0063
`define MCLK_HZ       200000000
`define CAMCLK_MIN_HZ 500000
`define CAMCLK_MAX_HZ 40000000
`endif

// ---- inc/cam_front_pkg.sv ----
// Types shared by the camera acquisition front end.
package cam_front_pkg;
    typedef struct packed {
        logic        pclk;
        logic        lval;
        logic        fval;
        logic        field;
        logic [15:0] data;
    } cam_in_t;
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic [15:0] x0;
        logic [15:0] y0;
        logic [15:0] x1;
        logic [15:0] y1;
    } pix_out_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SKIP = 3'b010,
        ST_ACQ  = 3'b100
    } acq_state_t;
endpackage

// ---- core/camera_acquisition_front_end.sv ----
// Camera acquisition front end: windowing, lookup, tap formatting, triggers, camera clock.
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cam_front_consts.svh"

// Behaviour
// - One table: one 16-bit or two 8-bit.
// - Table contents written by software.
// - Two 8-bit taps placed in raster order.
// - Per-tap horizontal and vertical scan reversal.
// - Trigger start edge chosen per line.
// - Trigger lines drivable as static outputs.
// - Timer pulses or status routed to triggers.
// - Four external, four bus triggers, polarity, direction.
// - All eight triggers usable as start sources.
// - Software start captures fixed frame count.
// - Start immediately or after skipped images.
// - Interlaced frame mode starts on chosen field.
// - Pixel window counted from line enable edge.
// - Line window counted from frame enable edge.
// - Second window selects region of interest.
// - Horizontal keep every 1, 2, 4, 8.
// - Vertical keep every 1, 2, 4, 8.
// - Decimation works with region of interest.
// - Interlaced fields interleaved into one frame.
// - Noninterlaced field is its own frame.
// - Only qualified pixels are forwarded.
// - Camera clock between 500 kHz and 40 MHz; the clamped divider tops out at 33.3 MHz.
module camera_acquisition_front_end (
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    input  wire logic [7:0]              s_axi_awaddr_i,
    input  wire logic                    s_axi_awvalid_i,
    output logic                         s_axi_awready_o,
    input  wire logic [31:0]             s_axi_wdata_i,
    input  wire logic [3:0]              s_axi_wstrb_i,
    input  wire logic                    s_axi_wvalid_i,
    output logic                         s_axi_wready_o,
    output logic [1:0]                   s_axi_bresp_o,
    output logic                         s_axi_bvalid_o,
    input  wire logic                    s_axi_bready_i,
    input  wire logic [7:0]              s_axi_araddr_i,
    input  wire logic                    s_axi_arvalid_i,
    output logic                         s_axi_arready_o,
    output logic [31:0]                  s_axi_rdata_o,
    output logic [1:0]                   s_axi_rresp_o,
    output logic                         s_axi_rvalid_o,
    input  wire logic                    s_axi_rready_i,
    input  wire cam_front_pkg::cam_in_t  cam_i,
    input  wire logic [7:0]              trig_i,
    output logic [7:0]                   trig_o,
    output logic [7:0]                   trig_oe_o,
    output logic                         camclk_o,
    output cam_front_pkg::pix_out_t      pix_o
);
    localparam logic [15:0] DIV_MIN = 16'((`MCLK_HZ + 2 * `CAMCLK_MAX_HZ - 1)
                                          / (2 * `CAMCLK_MAX_HZ) - 1);
    localparam logic [15:0] DIV_MAX = 16'(`MCLK_HZ / (2 * `CAMCLK_MIN_HZ) - 1);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    endfunction

    function automatic logic in_span(input logic [15:0] v, input logic [15:0] s,
                                     input logic [15:0] n);
        logic [15:0] d;
        d = v - s;
        in_span = (v >= s) && (d < n);
    endfunction

    function automatic logic [15:0] flip(input logic [15:0] v, input logic [15:0] n,
                                         input logic en);
        flip = en ? 16'(n - v - 16'h0001) : v;
    endfunction

    function automatic logic [15:0] dmask(input logic [1:0] sel);
        dmask = 16'((16'h0001 << sel) - 16'h0001);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers.
    logic [1:0] rst_sync;
    wire        rst_n = rst_sync[1];
    always_ff @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i) rst_sync <= 2'b00;
        else          rst_sync <= {rst_sync[0], 1'b1};

    cam_front_pkg::cam_in_t cam_s1, cam_s2;
    logic [7:0]             trig_s1, trig_s2;
    always_ff @(posedge mclk_i or negedge rst_n)
        if (!rst_n)
        begin
            cam_s1  <= '0;
            cam_s2  <= '0;
            trig_s1 <= 8'h00;
            trig_s2 <= 8'h00;
        end
        else
        begin
            cam_s1  <= cam_i;
            cam_s2  <= cam_s1;
            trig_s1 <= trig_i;
            trig_s2 <= trig_s1;
        end

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus slave.
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [31:0] ctrl, frames, skip, win_pix, win_line, roi_pix, roi_line;
    logic [31:0] decim, trig_cfg, trig_out, timer_per;
    logic [15:0] camclk_div, lut_addr;
    logic [15:0] frames_done;
    logic [15:0] lut_mem [0:65535];
    cam_front_pkg::acq_state_t state, next_state;

    wire do_write = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
    wire sel_ctrl = aw_addr == `OFF_CTRL;
    wire sel_lut  = aw_addr == `OFF_LUT_DATA;
    wire w_map    = aw_addr <= `OFF_LUT_DATA && aw_addr[1:0] == 2'b00;
    wire r_map    = s_axi_araddr_i <= `OFF_LUT_DATA && s_axi_araddr_i[1:0] == 2'b00;
    wire sw_start = do_write && sel_ctrl && w_strb[0] && w_data[`CTRL_START];
    wire lut_we   = do_write && sel_lut;
    wire [31:0] status_word = {frames_done, 13'h0000, state};
    wire [31:0] rd_word =
        s_axi_araddr_i == `OFF_CTRL     ? ctrl :
        s_axi_araddr_i == `OFF_STATUS   ? status_word :
        s_axi_araddr_i == `OFF_FRAMES   ? frames :
        s_axi_araddr_i == `OFF_SKIP     ? skip :
        s_axi_araddr_i == `OFF_WIN_PIX  ? win_pix :
        s_axi_araddr_i == `OFF_WIN_LINE ? win_line :
        s_axi_araddr_i == `OFF_ROI_PIX  ? roi_pix :
        s_axi_araddr_i == `OFF_ROI_LINE ? roi_line :
        s_axi_araddr_i == `OFF_DECIM    ? decim :
        s_axi_araddr_i == `OFF_TRIG_CFG ? trig_cfg :
        s_axi_araddr_i == `OFF_TRIG_OUT ? trig_out :
        s_axi_araddr_i == `OFF_TIMER    ? timer_per :
        s_axi_araddr_i == `OFF_CAMCLK   ? {16'h0000, camclk_div} :
        s_axi_araddr_i == `OFF_LUT_ADDR ? {16'h0000, lut_addr} : 32'h0000_0000;

    always_ff @(posedge mclk_i or negedge rst_n)
        if (!rst_n)
        begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= 2'b00;
            aw_addr         <= 8'h00;
            w_data          <= 32'h0000_0000;
            w_strb          <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_addr         <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_data         <= s_axi_wdata_i;
                w_strb         <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= w_map ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid_o && s_axi_bready_i)
            begin
                s_axi_bvalid_o  <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
            end
        end

    always_ff @(posedge mclk_i or negedge rst_n)
        if (!rst_n)
        begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= 2'b00;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= r_map ? rd_word : 32'h0000_0000;
            s_axi_rresp_o   <= r_map ? 2'b00 : 2'b10;
        end
        else if (s_axi_rvalid_o && s_axi_rready_i)
        begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end

    // The start bit is a command and never reads back as set.
    always_ff @(posedge mclk_i or negedge rst_n)
        if (!rst_n)
        begin
            ctrl       <= `RST_CTRL;
            frames     <= 32'h0000_0001;
            skip       <= 32'h0000_0000;
            win_pix    <= `RST_WIN;
            win_line   <= `RST_WIN;
            roi_pix    <= `RST_WIN;
            roi_line   <= `RST_WIN;
            decim      <= 32'h0000_0000;
            trig_cfg   <= 32'h0000_0000;
            trig_out   <= 32'h0000_0000;
            timer_per  <= 32'h0000_0000;
            camclk_div <= `RST_CAMCLK;
            lut_addr   <= 16'h0000;
        end
        else if (do_write)
        begin
            case (aw_addr)
                `OFF_CTRL:     ctrl      <= merge(ctrl, w_data, w_strb) & 32'h0000_001E;
                `OFF_FRAMES:   frames    <= merge(frames, w_data, w_strb);
                `OFF_SKIP:     skip      <= merge(skip, w_data, w_strb);
                `OFF_WIN_PIX:  win_pix   <= merge(win_pix, w_data, w_strb);
                `OFF_WIN_LINE: win_line  <= merge(win_line, w_data, w_strb);
                `OFF_ROI_PIX:  roi_pix   <= merge(roi_pix, w_data, w_strb);
                `OFF_ROI_LINE: roi_line  <= merge(roi_line, w_data, w_strb);
                `OFF_DECIM:    decim     <= merge(decim, w_data, w_strb);
                `OFF_TRIG_CFG: trig_cfg  <= merge(trig_cfg, w_data, w_strb);
                `OFF_TRIG_OUT: trig_out  <= merge(trig_out, w_data, w_strb);
                `OFF_TIMER:    timer_per <= merge(timer_per, w_data, w_strb);
                `OFF_CAMCLK:   camclk_div <= w_data[15:0];
                `OFF_LUT_ADDR: lut_addr  <= w_data[15:0];
                `OFF_LUT_DATA: lut_addr  <= 16'(lut_addr + 16'h0001);
                default:       lut_addr  <= lut_addr;
            endcase
        end

    always_ff @(posedge mclk_i)
        if (lut_we)
            lut_mem[lut_addr] <= w_data[15:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger lines: edge detection in, routed sources out.
    wire [7:0] trig_pol = trig_cfg[7:0];
    wire [7:0] trig_dir = trig_cfg[15:8];
    wire [7:0] trig_en  = trig_cfg[23:16];
    wire [7:0] trig_lvl = trig_s2 ^ trig_pol;
    logic [7:0] trig_prev;
    // The raw pin history is kept, so a polarity change alone never looks like an edge.
    wire [7:0] trig_hit = (trig_s2 ^ trig_prev) & trig_lvl & trig_en & ~trig_dir;
    wire       trig_start = |trig_hit;
    logic [31:0] timer_cnt;
    logic        timer_pulse;
    logic        in_frame;
    logic [7:0]  next_trig;

    always_comb
    begin
        for (int i = 0; i < 8; i++)
            case (trig_out[2*i +: 2])
                2'd0:    next_trig[i] = trig_out[16 + i] ^ trig_pol[i];
                2'd1:    next_trig[i] = timer_pulse ^ trig_pol[i];
                2'd2:    next_trig[i] = (state != cam_front_pkg::ST_IDLE) ^ trig_pol[i];
                default: next_trig[i] = in_frame ^ trig_pol[i];
            endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n)
        if (!rst_n)
        begin
            trig_prev   <= 8'h00;
            trig_o      <= 8'h00;
            trig_oe_o   <= 8'h00;
            timer_cnt   <= 32'h0000_0000;
            timer_pulse <= 1'b0;
        end
        else
        begin
            trig_prev   <= trig_s2;
            trig_o      <= next_trig;
            trig_oe_o   <= trig_dir;
            timer_pulse <= (timer_per != 32'h0000_0000) && (timer_cnt == timer_per);
            timer_cnt   <= (timer_cnt >= timer_per) ? 32'h0000_0000 : 32'(timer_cnt + 1);
        end

    ////////////////////////////////////////////////////////////////////////////////
    // Camera clock divider; the divide value is clamped to the legal band.
    wire [15:0] div_eff = camclk_div < DIV_MIN ? DIV_MIN :
                          camclk_div > DIV_MAX ? DIV_MAX : camclk_div;
    logic [15:0] cc_cnt;
    always_ff @(posedge mclk_i or negedge rst_n)
        if (!rst_n)
        begin
            cc_cnt   <= 16'h0000;
            camclk_o <= 1'b0;
        end
        else if (cc_cnt >= div_eff)
        begin
            cc_cnt   <= 16'h0000;
            camclk_o <= ~camclk_o;
        end
        else
            cc_cnt <= 16'(cc_cnt + 16'h0001);

    ////////////////////////////////////////////////////////////////////////////////
    // Pixel and line counting on sampled pixel clock edges.
    logic        pclk_d, lval_d, fval_d;
    logic [15:0] pix_cnt, line_cnt;
    wire pclk_rise = cam_s2.pclk & ~pclk_d;
    wire lval_rise = pclk_rise & cam_s2.lval & ~lval_d;
    wire lval_fall = pclk_rise & ~cam_s2.lval & lval_d;
    // Frame enable edges are seen even while the camera stops its pixel clock.
    wire fval_rise = cam_s2.fval & ~fval_d;
    wire fval_fall = ~cam_s2.fval & fval_d;
    wire pix_evt   = pclk_rise & cam_s2.lval & cam_s2.fval;
    wire [15:0] cur_pix  = lval_rise ? 16'h0000 : pix_cnt;
    wire [15:0] cur_line = line_cnt;

    always_ff @(posedge mclk_i or negedge rst_n)
        if (!rst_n)
        begin
            pclk_d   <= 1'b0;
            lval_d   <= 1'b0;
            fval_d   <= 1'b0;
            pix_cnt  <= 16'h0000;
            line_cnt <= 16'h0000;
        end
        else
        begin
            pclk_d <= cam_s2.pclk;
            fval_d <= cam_s2.fval;
            if (pclk_rise)
                lval_d <= cam_s2.lval;
            if (pix_evt)
                pix_cnt <= 16'(cur_pix + 16'h0001);
            if (fval_rise)
                line_cnt <= 16'h0000;
            else if (lval_fall)
                line_cnt <= 16'(line_cnt + 16'h0001);
        end

    ////////////////////////////////////////////////////////////////////////////////
    // Window, region of interest and decimation qualification.
    wire [15:0] rx = cur_pix - win_pix[15:0];
    wire [15:0] ry = cur_line - win_line[15:0];
    wire [15:0] qx = rx - roi_pix[15:0];
    wire [15:0] qy = ry - roi_line[15:0];
    wire in_win = in_span(cur_pix, win_pix[15:0], win_pix[31:16])
               && in_span(cur_line, win_line[15:0], win_line[31:16]);
    wire in_roi = in_span(rx, roi_pix[15:0], roi_pix[31:16])
               && in_span(ry, roi_line[15:0], roi_line[31:16]);
    wire keep_h = (qx & dmask(decim[1:0])) == 16'h0000;
    wire keep_v = (qy & dmask(decim[3:2])) == 16'h0000;
    wire keep   = pix_evt && in_frame && in_win && in_roi && keep_h && keep_v;

    // Output geometry after decimation, used to mirror reversed taps.
    wire [15:0] out_w = 16'((roi_pix[31:16] + dmask(decim[1:0])) >> decim[1:0]);
    wire [15:0] out_h = 16'((roi_line[31:16] + dmask(decim[3:2])) >> decim[3:2]);
    wire [15:0] ox    = qx >> decim[1:0];
    wire [15:0] oy    = qy >> decim[3:2];
    wire        interl = ctrl[`CTRL_INTERL];
    wire [15:0] y_t0 = flip(oy, out_h, decim[`DEC_TAP0_V]);
    wire [15:0] y_t1 = flip(oy, out_h, decim[`DEC_TAP1_V]);
    wire [15:0] fy0  = interl ? {y_t0[14:0], cam_s2.field} : y_t0;
    wire [15:0] fy1  = interl ? {y_t1[14:0], cam_s2.field} : y_t1;

    // Lookup: sixteen-bit index, or both taps through entries 0 to 255, the low tap taking the low byte and the high tap the high byte.
    wire [15:0] lut_wide = lut_mem[cam_s2.data];
    wire [15:0] lut_lo   = lut_mem[{8'h00, cam_s2.data[7:0]}];
    wire [15:0] lut_hi   = lut_mem[{8'h00, cam_s2.data[15:8]}];
    wire [15:0] lut_pix  = !ctrl[`CTRL_LUT_EN] ? cam_s2.data :
                           ctrl[`CTRL_LUT16]   ? lut_wide :
                           {lut_hi[15:8], lut_lo[7:0]};

    always_ff @(posedge mclk_i or negedge rst_n)
        if (!rst_n)
            pix_o <= '0;
        else
        begin
            pix_o.valid <= keep;
            if (keep)
            begin
                pix_o.data <= lut_pix;
                pix_o.x0   <= flip(ox, out_w, decim[`DEC_TAP0_H]);
                pix_o.x1   <= flip(ox, out_w, decim[`DEC_TAP1_H]);
                pix_o.y0   <= fy0;
                pix_o.y1   <= fy1;
            end
        end

    ////////////////////////////////////////////////////////////////////////////////
    // Acquisition sequencing: start, skip, field choice, frame count.
    logic [31:0] skip_left;
    logic        half;
    wire field_ok   = !interl || (cam_s2.field == ctrl[`CTRL_EVEN]);
    wire frame_end  = fval_fall && in_frame && (!interl || half);
    wire last_frame = frames[15:0] != 16'h0000
                   && 16'(frames_done + 16'h0001) == frames[15:0];

    always_comb
    begin
        next_state = state;
        case (state)
            cam_front_pkg::ST_IDLE:
                if (sw_start || trig_start)
                    next_state = cam_front_pkg::ST_SKIP;
            cam_front_pkg::ST_SKIP:
                if (fval_rise && skip_left == 32'h0000_0000 && field_ok)
                    next_state = cam_front_pkg::ST_ACQ;
            cam_front_pkg::ST_ACQ:
                if (frame_end && last_frame)
                    next_state = cam_front_pkg::ST_IDLE;
            default:
                next_state = cam_front_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n)
        if (!rst_n)
        begin
            state       <= cam_front_pkg::ST_IDLE;
            skip_left   <= 32'h0000_0000;
            frames_done <= 16'h0000;
            in_frame    <= 1'b0;
            half        <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (state == cam_front_pkg::ST_IDLE && next_state == cam_front_pkg::ST_SKIP)
            begin
                skip_left   <= skip;
                frames_done <= 16'h0000;
            end
            else if (state == cam_front_pkg::ST_SKIP && fval_rise && field_ok
                     && skip_left != 32'h0000_0000)
                skip_left <= 32'(skip_left - 1);
            if (next_state == cam_front_pkg::ST_ACQ && state == cam_front_pkg::ST_SKIP)
            begin
                in_frame <= 1'b1;
                half     <= 1'b0;
            end
            else if (frame_end)
            begin
                frames_done <= 16'(frames_done + 16'h0001);
                in_frame    <= !last_frame;
                half        <= 1'b0;
            end
            else if (fval_fall && in_frame)
                half <= 1'b1;
        end
endmodule
`default_nettype wire

// ---- tb/camera_acquisition_front_end_monitor.sv ----
// Port-level assertions for the camera acquisition front end.
`timescale 1ns/1ps
`default_nettype none
module camera_acquisition_front_end_monitor (
    input wire logic                    mclk_i,
    input wire logic                    rst_n_i,
    input wire logic                    s_axi_bvalid_o,
    input wire logic                    s_axi_bready_i,
    input wire logic                    s_axi_arvalid_i,
    input wire logic                    s_axi_arready_o,
    input wire logic                    s_axi_rvalid_o,
    input wire logic                    s_axi_rready_i,
    input wire logic                    camclk_o,
    input wire cam_front_pkg::pix_out_t pix_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_AR_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer not one cycle after address");
    AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
        else $error("read answer dropped before handshake");
    AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write answer dropped before handshake");
    AST_B_DROP: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("write answer repeated after handshake");
    AST_PIX_ONE: assert property (pix_o.valid |=> !pix_o.valid)
        else $error("pixel strobe longer than one cycle");
    AST_PIX_HOLD: assert property (!pix_o.valid |-> $stable(pix_o.data))
        else $error("pixel data moved without a strobe");
    AST_CLK_MIN: assert property ($changed(camclk_o) |=> $stable(camclk_o) [*2])
        else $error("camera clock faster than the upper limit");
    AST_CLK_MAX: assert property ($changed(camclk_o) |-> ##[1:200] $changed(camclk_o))
        else $error("camera clock slower than the lower limit");
endmodule
bind camera_acquisition_front_end camera_acquisition_front_end_monitor u_mon (.*);
`default_nettype wire

// ---- tb/cam_model.sv ----
// Behavioural camera that sends two-tap frames with a slow pixel clock.
`timescale 1ns/1ps
`default_nettype none
module cam_model (
    input  wire logic              mclk_i,
    output cam_front_pkg::cam_in_t cam_o
);
    logic [15:0] last = '0;
    initial cam_o = '0;
    // Data and line enable change while the pixel clock is low.
    task automatic tick(input logic lv, input logic [15:0] d);
        @(posedge mclk_i);
        cam_o.pclk <= 1'b0;
        cam_o.lval <= lv;
        cam_o.data <= lv ? d : ~last;
        if (lv)
            last = d;
        repeat (4) @(posedge mclk_i);
        cam_o.pclk <= 1'b1;
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic frame(input int nl, input int np);
        @(posedge mclk_i);
        cam_o.fval <= 1'b1;
        for (int l = 0; l < nl; l++)
        begin
            for (int p = 0; p < np; p++)
                tick(1'b1, {l[7:0], p[7:0]});
            repeat (3) tick(1'b0, '0);
        end
        @(posedge mclk_i);
        cam_o.fval <= 1'b0;
        cam_o.pclk <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_camera_acquisition_front_end.sv ----
// Self-checking bench for the camera acquisition front end.
`timescale 1ns/1ps
`default_nettype none
`include "cam_front_consts.svh"
module tb_camera_acquisition_front_end;
    logic [7:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0, trig_v = '0;
    logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, r_d;
    logic [3:0]  s_axi_wstrb_i = 4'hf;
    logic        mclk_i = '0, rst_n_i = '0, s_axi_awvalid_i = '0, s_axi_wvalid_i = '0;
    logic        s_axi_bready_i = '0, s_axi_arvalid_i = '0, s_axi_rready_i = '0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic        s_axi_rvalid_o, camclk_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r_s;
    logic [7:0]  trig_o, trig_oe_o;
    wire logic [7:0] trig_i;
    cam_front_pkg::cam_in_t  cam_i;
    cam_front_pkg::pix_out_t pix_o;
    int          n_fail = 0, checks = 0, npix = 0, n;
    logic [15:0] first;
    camera_acquisition_front_end u_dut (.*);
    cam_model u_cam (.mclk_i(mclk_i), .cam_o(cam_i));
    assign trig_i = (trig_oe_o & trig_o) | (~trig_oe_o & trig_v);
    always #2.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
        if (pix_o.valid === 1'b1)
        begin
            if (npix == 0)
                first = pix_o.data;
            npix++;
        end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One register transfer; w selects a write, otherwise a read into r_d and r_s.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        s_axi_awaddr_i <= a;
        s_axi_araddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= w;
        s_axi_wvalid_i <= w;
        s_axi_bready_i <= w;
        s_axi_arvalid_i <= !w;
        s_axi_rready_i <= !w;
        for (n = 0; n < 64; n++)
        begin
            @(posedge mclk_i);
            if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
            if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
            if ((w ? s_axi_bvalid_o : s_axi_rvalid_o) === 1'b1) break;
        end
        r_d = s_axi_rdata_o;
        r_s = s_axi_rresp_o;
        s_axi_bready_i <= 1'b0;
        s_axi_rready_i <= 1'b0;
        chk("bus answer", {31'h0, n < 64}, 32'h0000_0001);
        if (n == 64) conclude();
    endtask
    task automatic t_regs();
        xfer(0, `OFF_CAMCLK, '0);
        chk("camclk divider", r_d, 32'h0000_0063);
        xfer(0, 8'h3c, '0);
        chk("unmapped resp", {30'h0, r_s}, 32'h0000_0002);
        xfer(1, `OFF_TRIG_CFG, 32'h0000_0100);
        xfer(1, `OFF_TRIG_OUT, 32'h0001_0000);
        @(posedge mclk_i);
        chk("trig drive", {16'h0, trig_oe_o, trig_o}, 32'h0000_0101);
        $display("test regs done");
    endtask
    task automatic t_window();
        xfer(1, `OFF_WIN_PIX, 32'h0008_0002);
        xfer(1, `OFF_WIN_LINE, 32'h0003_0001);
        xfer(1, `OFF_ROI_PIX, 32'h000a_0002);
        xfer(1, `OFF_ROI_LINE, 32'h0003_0000);
        xfer(1, `OFF_DECIM, 32'h0000_0001);
        xfer(1, `OFF_TRIG_CFG, 32'h0010_0010);
        trig_v <= 8'h10;
        repeat (8) @(posedge mclk_i);
        xfer(0, `OFF_STATUS, '0);
        chk("idle after rise", r_d & 32'h0000_0007, 32'h0000_0001);
        trig_v <= 8'h00;
        repeat (8) @(posedge mclk_i);
        xfer(0, `OFF_STATUS, '0);
        chk("start after fall", {31'h0, r_d[2:0] == 3'b001}, '0);
        npix = 0;
        u_cam.frame(5, 12);
        repeat (20) @(posedge mclk_i);
        chk("kept pixels", 32'(npix), 32'h0000_0009);
        chk("first pixel", {16'h0, first}, 32'h0000_0104);
        xfer(0, `OFF_STATUS, '0);
        chk("one frame", r_d & 32'hffff_0007, 32'h0001_0001);
        $display("test window done");
    endtask
    task automatic t_lut();
        xfer(1, `OFF_LUT_ADDR, 32'h0000_0004);
        xfer(1, `OFF_LUT_DATA, 32'h0000_00c3);
        xfer(1, `OFF_LUT_ADDR, 32'h0000_0001);
        xfer(1, `OFF_LUT_DATA, 32'h0000_5a00);
        xfer(1, `OFF_CTRL, 32'h0000_0011);
        npix = 0;
        u_cam.frame(5, 12);
        repeat (20) @(posedge mclk_i);
        chk("mapped pixel", {16'h0, first}, 32'h0000_5ac3);
        $display("test lut done");
    endtask
    initial
    begin
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        t_regs();
        t_window();
        t_lut();
        conclude();
    end
endmodule
`default_nettype wire
